// ===== logic/run_control_pkg.sv
// Package: register map, field layout, codes and carriers for the core run control
package run_control_pkg;

  // ************************************************************
  // Register map (printed offsets, port addressing)
  // ************************************************************
  localparam logic [15:0] sleep_request_addr = 16'hF400;
  localparam logic [15:0] pulse_select_addr = 16'hF401;
  localparam logic [15:0] run_trigger_addr = 16'hF402;
  localparam logic [15:0] abort_trigger_addr = 16'hF403;
  localparam logic [15:0] start_address_addr = 16'hF404;
  localparam logic [15:0] core_state_addr = 16'hF405;

  // ************************************************************
  // Reset values and field positions
  // ************************************************************
  localparam logic sleep_request_reset = 1'h0;
  localparam logic [4:0] pulse_select_reset = 5'h02;
  localparam logic run_trigger_reset = 1'h0;
  localparam logic abort_trigger_reset = 1'h0;
  localparam logic [15:0] start_address_reset = 16'h0000;
  localparam int trigger_bit = 0;
  localparam int pulse_select_width = 5;
  localparam int core_state_width = 3;

  // ************************************************************
  // Frame pulse sources
  // ************************************************************
  localparam logic [4:0] pulse_gen1_first = 5'h00;
  localparam logic [4:0] pulse_gen2_first = 5'h05;
  localparam logic [4:0] pulse_serial_in_first = 5'h08;
  localparam logic [4:0] pulse_serial_out_first = 5'h0C;
  localparam logic [4:0] pulse_digital_rx = 5'h10;
  localparam int gen1_count = 5;
  localparam int gen2_count = 3;
  localparam int serial_count = 4;

  // ************************************************************
  // Reported core state codes
  // ************************************************************
  localparam logic [2:0] state_not_running = 3'h0;
  localparam logic [2:0] state_running = 3'h1;
  localparam logic [2:0] state_paused = 3'h2;
  localparam logic [2:0] state_sleeping = 3'h3;
  localparam logic [2:0] state_stalled = 3'h4;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic write;
    logic read;
  } reg_request_type;

  typedef struct packed {
    logic [4:0] gen1;
    logic [2:0] gen2;
    logic [3:0] serial_in;
    logic [3:0] serial_out;
    logic digital_rx;
  } frame_sources_type;

  typedef struct packed {
    logic paused;
    logic idle_wait;
    logic stalled;
    logic frame_done;
  } core_report_type;

endpackage : run_control_pkg

// ===== logic/frame_pulse_mux.sv
// Frame pulse selector: picks one of the frame start sources by code
`timescale 1ns/1ps
module frame_pulse_mux
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Selection
  input wire logic [4:0] select,
  input wire run_control_pkg::frame_sources_type sources,
  // Result
  output logic frame_pulse
);

  logic [16:0] flat;
  logic pick_d;
  logic pick_q;

  assign flat = {sources.digital_rx, sources.serial_out, sources.serial_in,
                 sources.gen2, sources.gen1};

  // Codes above the last source select nothing
  always_comb
  begin
    pick_d = 1'b0;
    if (select <= run_control_pkg::pulse_digital_rx)
    begin
      pick_d = flat[select];
    end
  end

  // Registered so the pulse never glitches on a selector change
  always_ff @(posedge clock)
  begin
    if (!resetn)
      pick_q <= 1'b0;
    else
      pick_q <= pick_d;
  end

  assign frame_pulse = pick_q;

endmodule : frame_pulse_mux

// ===== logic/rise_detect.sv
// Rising edge detector for a written trigger bit
`timescale 1ns/1ps
module rise_detect
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Write of the trigger bit
  input wire logic write_en,
  input wire logic write_bit,
  // Stored value and edge pulse
  output logic level,
  output logic rise
);

  logic level_q;
  logic rise_q;

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end
    else
    begin
      if (write_en)
        level_q <= write_bit;
      rise_q <= write_en && write_bit && !level_q;
    end
  end

  assign level = level_q;
  assign rise = rise_q;

endmodule : rise_detect

// ===== logic/core_run_control.sv
// Run control register bank and core run state sequencer
//
// Summary of operation
// - Sleep request set while processing: finish sample or block, then hibernate.
// - While hibernating all core interrupts are masked, audio stops.
// - Sleep request bit: 0 awake, interrupts on; 1 hibernate, interrupts off.
// - Five-bit frame pulse selector, reset code two, sets processing rate.
// - Codes 0 to 4 pick generator one outputs /4, /2, x1, x2, x4.
// - Codes 5 to 7 pick generator two quarter, half and unity outputs.
// - Codes 8 to 11 serial input frames, 12 to 15 serial output frames.
// - Code 16 picks the digital audio receiver recovered rate.
// - Rising edge of run trigger enables core and starts program counter.
// - Falling edge of run trigger has no effect.
// - Rising edge of abort trigger halts core at once.
// - Falling edge of abort trigger has no effect.
// - Program counter starts at the sixteen-bit start address, reset zero.
// - Read-only state: 0 stopped, 1 running, 2 paused, 3 sleeping, 4 stalled.
`timescale 1ns/1ps
module core_run_control
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Frame pulse sources, same clock
  input wire run_control_pkg::frame_sources_type frame_sources,
  // Core reports, same clock
  input wire run_control_pkg::core_report_type core_report,
  // Core control
  output logic core_enable,
  output logic pc_load,
  output logic [15:0] pc_start,
  output logic core_halt,
  output logic irq_mask,
  output logic frame_start,
  output logic [2:0] core_state
);

  // ************************************************************
  // Run state
  // ************************************************************
  typedef enum logic [1:0] {stopped, active, draining, hibernating} run_type;

  run_type run_q;
  run_type run_d;
  run_control_pkg::reg_request_type req;
  logic sleep_q;
  logic [4:0] select_q;
  logic [15:0] start_addr_q;
  logic run_level;
  logic run_rise;
  logic abort_level;
  logic abort_rise;
  logic frame_pulse;
  logic enable_q;
  logic load_q;
  logic halt_q;
  logic mask_q;
  logic frame_q;
  logic [2:0] state_q;
  logic [15:0] rdata_q;
  logic [2:0] state_d;

  assign req = '{addr: reg_addr, wdata: reg_wdata, write: reg_write, read: reg_read};

  // ************************************************************
  // Writable registers
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (!resetn)
      sleep_q <= run_control_pkg::sleep_request_reset;
    else if (req.write && req.addr == run_control_pkg::sleep_request_addr)
      sleep_q <= req.wdata[run_control_pkg::trigger_bit];
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      select_q <= run_control_pkg::pulse_select_reset;
    else if (req.write && req.addr == run_control_pkg::pulse_select_addr)
      select_q <= req.wdata[run_control_pkg::pulse_select_width-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      start_addr_q <= run_control_pkg::start_address_reset;
    else if (req.write && req.addr == run_control_pkg::start_address_addr)
      start_addr_q <= req.wdata;
  end

  // ************************************************************
  // Trigger edges and frame pulse selector
  // ************************************************************
  rise_detect run_edge
  (
    .clock(clock),
    .resetn(resetn),
    .write_en(req.write && req.addr == run_control_pkg::run_trigger_addr),
    .write_bit(req.wdata[run_control_pkg::trigger_bit]),
    .level(run_level),
    .rise(run_rise)
  );

  rise_detect abort_edge
  (
    .clock(clock),
    .resetn(resetn),
    .write_en(req.write && req.addr == run_control_pkg::abort_trigger_addr),
    .write_bit(req.wdata[run_control_pkg::trigger_bit]),
    .level(abort_level),
    .rise(abort_rise)
  );

  frame_pulse_mux pulse_mux
  (
    .clock(clock),
    .resetn(resetn),
    .select(select_q),
    .sources(frame_sources),
    .frame_pulse(frame_pulse)
  );

  // ************************************************************
  // Run sequencer
  // ************************************************************
  // Abort wins over everything; falling trigger edges are simply ignored
  always_comb
  begin
    run_d = run_q;
    case (run_q)
      stopped:
        if (run_rise)
          run_d = sleep_q ? hibernating : active;
      active:
        if (sleep_q)
          run_d = draining;
      draining:
        if (core_report.frame_done)
          run_d = hibernating;
        else if (!sleep_q)
          run_d = active;
      hibernating:
        if (!sleep_q)
          run_d = active;
      default:
        run_d = stopped;
    endcase
    if (abort_rise)
      run_d = stopped;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      run_q <= stopped;
    else
      run_q <= run_d;
  end

  // ************************************************************
  // Core control outputs
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      enable_q <= 1'b0;
      load_q <= 1'b0;
      halt_q <= 1'b0;
    end
    else
    begin
      enable_q <= run_d != stopped;
      load_q <= run_rise && !abort_rise && run_q == stopped;
      halt_q <= abort_rise;
    end
  end

  // Mask follows the request bit at once; the core still finishes its frame
  always_ff @(posedge clock)
  begin
    if (!resetn)
      mask_q <= 1'b0;
    else
      mask_q <= sleep_q || run_d == hibernating;
  end

  // Frame pulses are held back while interrupts are masked
  always_ff @(posedge clock)
  begin
    if (!resetn)
      frame_q <= 1'b0;
    else
      frame_q <= frame_pulse && !mask_q && run_q != stopped;
  end

  // ************************************************************
  // State report and read port
  // ************************************************************
  always_comb
  begin
    state_d = run_control_pkg::state_running;
    if (run_d == stopped)
      state_d = run_control_pkg::state_not_running;
    else if (run_d == hibernating || core_report.idle_wait)
      state_d = run_control_pkg::state_sleeping;
    else if (core_report.paused)
      state_d = run_control_pkg::state_paused;
    else if (core_report.stalled)
      state_d = run_control_pkg::state_stalled;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      state_q <= run_control_pkg::state_not_running;
    else
      state_q <= state_d;
  end

  // Unmapped addresses read zero; reserved bits read zero
  always_ff @(posedge clock)
  begin
    if (!resetn)
      rdata_q <= 16'h0000;
    else if (req.read)
      case (req.addr)
        run_control_pkg::sleep_request_addr: rdata_q <= {15'h0000, sleep_q};
        run_control_pkg::pulse_select_addr: rdata_q <= {11'h000, select_q};
        run_control_pkg::run_trigger_addr: rdata_q <= {15'h0000, run_level};
        run_control_pkg::abort_trigger_addr: rdata_q <= {15'h0000, abort_level};
        run_control_pkg::start_address_addr: rdata_q <= start_addr_q;
        run_control_pkg::core_state_addr: rdata_q <= {13'h0000, state_q};
        default: rdata_q <= 16'h0000;
      endcase
    else
      rdata_q <= 16'h0000;
  end

  assign reg_rdata = rdata_q;
  assign core_enable = enable_q;
  assign pc_load = load_q;
  assign pc_start = start_addr_q;
  assign core_halt = halt_q;
  assign irq_mask = mask_q;
  assign frame_start = frame_q;
  assign core_state = state_q;

endmodule : core_run_control

// ===== sim/core_run_control_monitor.sv
// Port checker of the core run control register bank
`timescale 1ns/1ps
module core_run_control_monitor
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // Sources and reports
  input wire run_control_pkg::frame_sources_type frame_sources,
  input wire run_control_pkg::core_report_type core_report,
  // Core control
  input wire logic core_enable,
  input wire logic pc_load,
  input wire logic [15:0] pc_start,
  input wire logic core_halt,
  input wire logic irq_mask,
  input wire logic frame_start,
  input wire logic [2:0] core_state
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ****
  // Write and drain steps
  // ****
  sequence wr_bit(a, b);
    reg_write && reg_addr == a && reg_wdata[0] == b;
  endsequence
  sequence drained;
    irq_mask && core_enable && core_report.frame_done;
  endsequence
  // ****
  // Properties
  // ****
  chk_load_cause: assert property (pc_load |-> $past(reg_write, 2) &&
    $past(reg_addr, 2) == run_control_pkg::run_trigger_addr && $past(reg_wdata[0], 2))
    else $error("program load without a run write");
  chk_load_enables: assert property (pc_load |-> core_enable)
    else $error("program load while core disabled");
  chk_run_fall: assert property (wr_bit(run_control_pkg::run_trigger_addr, 1'b0)
    |-> ##2 !pc_load)
    else $error("run clear started the core");
  chk_halt_cause: assert property (core_halt |-> $past(reg_write, 2) &&
    $past(reg_addr, 2) == run_control_pkg::abort_trigger_addr && $past(reg_wdata[0], 2))
    else $error("halt without an abort write");
  chk_halt_stops: assert property (core_halt |-> !core_enable &&
    core_state == run_control_pkg::state_not_running)
    else $error("halt left the core running");
  chk_halt_pulse: assert property (core_halt |=> !core_halt)
    else $error("halt longer than one cycle");
  chk_abort_fall: assert property (wr_bit(run_control_pkg::abort_trigger_addr, 1'b0)
    |-> ##2 !core_halt)
    else $error("abort clear halted the core");
  chk_mask_value: assert property (reg_write &&
    reg_addr == run_control_pkg::sleep_request_addr |->
    ##2 irq_mask == $past(reg_wdata[0], 2))
    else $error("interrupt mask differs from sleep bit");
  chk_sleep_entry: assert property (drained |=>
    core_state == run_control_pkg::state_sleeping)
    else $error("no hibernation after the last frame");
  chk_frame_cause: assert property (frame_start |-> $past(frame_sources, 2) != '0)
    else $error("frame start without a source pulse");
endmodule : core_run_control_monitor

bind core_run_control core_run_control_monitor mon (.*);

// ===== sim/core_run_control_tb_top.sv
// Self-checking bench of the core run control register bank
`timescale 1ns/1ps
module dsp_core_run_control_tb_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  run_control_pkg::frame_sources_type frame_sources = '0;
  run_control_pkg::core_report_type core_report = '0;
  logic core_enable, pc_load, core_halt, irq_mask, frame_start;
  logic [15:0] pc_start;
  logic [2:0] core_state;
  int err_count = 0;
  int check_count = 0;
  int regs [5] = '{0, 2, 0, 0, 0};
  int run_st = 0;
  int idx [3] = '{1, 4, 5};
  logic [15:0] rv;

  core_run_control dut
  (
    .clock(clock),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .frame_sources(frame_sources),
    .core_report(core_report),
    .core_enable(core_enable),
    .pc_load(pc_load),
    .pc_start(pc_start),
    .core_halt(core_halt),
    .irq_mask(irq_mask),
    .frame_start(frame_start),
    .core_state(core_state)
  );

  initial forever #20 clock = ~clock;

  initial
  begin
    repeat (20000) @(posedge clock);
    err_count++;
    conclude();
  end

  // ****
  // Model and tasks
  // ****
  function automatic int exp_rd(input int i);
    exp_rd = i < 5 ? regs[i] : i == 5 ? run_st : 0;
  endfunction : exp_rd

  function automatic run_control_pkg::frame_sources_type sel(input int c);
    logic [31:0] v;
    v = 0;
    if (c < 17) v[c] = 1'b1;
    sel = {v[4:0], v[7:5], v[11:8], v[15:12], v[16]};
  endfunction : sel

  task automatic check(input logic [15:0] got, input int exp, input string w);
    check_count++;
    if (got !== 16'(exp))
    begin
      $display("mismatch at %0t: %s got %h expected %h", $time, w, got, 16'(exp));
      err_count++;
    end
  endtask : check

  task automatic put(input int i, input int d);
    @(posedge clock);
    reg_addr <= 16'hF400 + 16'(i);
    reg_wdata <= 16'(d);
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    if (i == 2 && d % 2 == 1 && regs[2] == 0 && run_st == 0) run_st = regs[0] == 1 ? 3 : 1;
    if (i == 3 && d % 2 == 1 && regs[3] == 0) run_st = 0;
    if (i < 5) regs[i] = d & (i == 4 ? 'hFFFF : i == 1 ? 'h1F : 1);
  endtask : put

  task automatic rd(input int i, output logic [15:0] q);
    @(posedge clock);
    reg_addr <= 16'hF400 + 16'(i);
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd

  task automatic pulse(input run_control_pkg::frame_sources_type s);
    @(posedge clock);
    frame_sources <= s;
    @(posedge clock);
    frame_sources <= '0;
  endtask : pulse

  // Outputs packed as enable, load, halt, mask, frame, state
  task automatic look(input int n, input int ld, input int ht, input int fs, input string w);
    repeat (n) @(posedge clock);
    #1 check({8'h00, core_enable, pc_load, core_halt, irq_mask, frame_start, core_state},
      (run_st != 0) * 128 + ld * 64 + ht * 32 + regs[0] * 16 + fs * 8 + run_st, w);
  endtask : look

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // ****
  // Tests
  // ****
  initial
  begin
    void'($urandom(36122));
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      rd(i, rv);
      check(rv, exp_rd(i), "reset value");
    end
    for (int i = 0; i < 9; i++)
    begin
      put(idx[i % 3], $urandom);
      rd(idx[i % 3], rv);
      check(rv, exp_rd(idx[i % 3]), "readback");
    end
    $display("test registers done");
    put(2, 1);
    look(1, 1, 0, 0, "run rise");
    check(pc_start, regs[4], "start address");
    put(2, 1);
    look(1, 0, 0, 0, "run rewrite");
    put(2, 0);
    look(1, 0, 0, 0, "run fall");
    // Paused, idle wait and stalled reports in turn
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clock);
      core_report <= 4'(8 >> k);
      @(posedge clock);
      core_report <= 4'h0;
      #1 check(16'(core_state), 2 + k, "core report");
    end
    $display("test start done");
    for (int c = 0; c < 18; c++)
    begin
      put(1, c);
      pulse(~sel(c));
      look(1, 0, 0, 0, "other source");
      pulse(sel(c));
      look(1, 0, 0, c < 17, "selected source");
    end
    $display("test frame select done");
    put(1, 2);
    put(0, 1);
    look(1, 0, 0, 0, "sleep mask");
    pulse(sel(2));
    look(1, 0, 0, 0, "masked frame");
    // No other control write until the core reports its block done
    @(posedge clock);
    core_report <= 4'h1;
    @(posedge clock);
    core_report <= 4'h0;
    run_st = 3;
    look(1, 0, 0, 0, "hibernate");
    pulse(sel(2));
    look(1, 0, 0, 0, "hibernate masked");
    put(0, 0);
    run_st = 1;
    look(1, 0, 0, 0, "wake");
    pulse(sel(2));
    look(1, 0, 0, 1, "resumed frame");
    $display("test sleep done");
    foreach (idx[k])
    begin
      put(3, k % 2 == 0 ? 1 : 0);
      look(1, 0, k == 0 || k == 2, 0, "abort write");
    end
    put(3, 1);
    look(1, 0, 0, 0, "abort rewrite");
    put(2, 1);
    look(1, 1, 0, 0, "restart");
    $display("test abort done");
    // Reset in mid-run clears the stored trigger levels too
    @(posedge clock);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    regs = '{0, 2, 0, 0, 0};
    run_st = 0;
    look(1, 0, 0, 0, "reset again");
    rd(1, rv);
    check(rv, exp_rd(1), "select after reset");
    put(2, 1);
    look(1, 1, 0, 0, "run after reset");
    $display("test second reset done");
    conclude();
  end
endmodule : dsp_core_run_control_tb_top
